/* File: ctp_pkg.sv */
// package for the cascadable timer/counter pair: constants, modes and state types
//
// Function
// - upper mode msb set: upper counter clocked by lower overflow, not own clock select
// - 16-bit: clock from lower clock select; run from upper unit, each flip-flop preset from its own unit's control
// - normal/idle: permitted sources per mode, timers use four prescaler taps or the pin
// - slow/sleep: permitted sources per mode, timers use slowest tap or the pin
// - timer mode: count selected clock, on compare match raise interrupt and clear
// - compare period not double-buffered: writes act at once
// - each unit 8-bit modes; cascaded pair gives 16-bit modes
// - 3-bit mode field decoding: 000 timer, 001 divider, 010 pwm, 1xx 16-bit
package ctp_pkg;
   localparam logic [2:0] CTP_MODE_TIMER = 3'h0;
   localparam logic [2:0] CTP_MODE_DIV = 3'h1;
   localparam logic [2:0] CTP_MODE_PWM8 = 3'h2;
   localparam logic [2:0] CTP_MODE_LOWER16 = 3'h3;
   localparam logic [2:0] CTP_MODE_T16 = 3'h4;
   localparam logic [2:0] CTP_MODE_WARM = 3'h5;
   localparam logic [2:0] CTP_MODE_PWM16 = 3'h6;
   localparam int CTP_MODE_MSB = 2;
   // clock select codes
   localparam logic [2:0] CTP_CK_TAP11 = 3'h0;
   localparam logic [2:0] CTP_CK_TAP7 = 3'h1;
   localparam logic [2:0] CTP_CK_TAP5 = 3'h2;
   localparam logic [2:0] CTP_CK_TAP3 = 3'h3;
   localparam logic [2:0] CTP_CK_LOWF = 3'h4;
   localparam logic [2:0] CTP_CK_HALF = 3'h5;
   localparam logic [2:0] CTP_CK_HIGH = 3'h6;
   localparam logic [2:0] CTP_CK_PIN = 3'h7;
   localparam logic [7:0] CTP_CNT_ZERO = 8'h00;
   localparam logic [7:0] CTP_CNT_ONE = 8'h01;
   localparam logic [7:0] CTP_CNT_MAX = 8'hFF;

   typedef struct packed {
      logic [2:0] mode;
      logic [2:0] clk_sel;
      logic run;
      logic ff_ctl;
   } ctp_ctrl_t;

   // per-unit state
   typedef struct packed {
      logic [7:0] count;
      logic run_d;
      logic ff;
      logic match;
      logic ovf;
   } ctp_unit_t;

   typedef enum logic [2:0] {
      CTP_ST_IDLE = 3'b001,
      CTP_ST_ARM = 3'b010,
      CTP_ST_RUN = 3'b100
   } ctp_state_t;
endpackage : ctp_pkg

/* File: ctp_unit.sv */
// one 8-bit up-counter unit with compare, divider and pwm flip-flop
`timescale 1ns/10ps
`default_nettype none
module ctp_unit
   import ctp_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_run,
   input wire logic i_tick,
   input wire logic [2:0] i_mode,
   input wire logic i_ff_ctl,
   input wire logic [7:0] i_period,
   input wire logic [7:0] i_width,
   input wire logic i_cascade_low,
   output logic [7:0] o_count,
   output logic o_match,
   output logic o_ovf,
   output logic o_ff
);
   ctp_unit_t s_r;
   ctp_unit_t s_nxt;

   // counting, compare and flip-flop update
   always_comb begin
      s_nxt = s_r;
      s_nxt.match = 1'b0;
      s_nxt.ovf = 1'b0;
      s_nxt.run_d = i_run;
      if (!i_run) begin
         s_nxt.count = CTP_CNT_ZERO;
         if (s_r.run_d == 1'b0) begin
            s_nxt.ff = i_ff_ctl; // preset only while idle; pins hold level for the first stopped cycle, then take the preset
         end
      end else if (i_tick) begin
         if (i_cascade_low) begin
            // low half of a 16-bit chain just wraps and feeds the upper unit
            s_nxt.count = s_r.count + CTP_CNT_ONE;
            s_nxt.ovf = (s_r.count == CTP_CNT_MAX);
         end else if (i_mode == CTP_MODE_PWM8) begin
            s_nxt.count = s_r.count + CTP_CNT_ONE;
            if (s_r.count == CTP_CNT_MAX) begin
               s_nxt.ff = ~s_r.ff;
               s_nxt.match = 1'b1;
               s_nxt.ovf = 1'b1;
            end else if (s_r.count + CTP_CNT_ONE == i_width) begin
               s_nxt.ff = ~s_r.ff;
            end
         // a zero period never matches: the counter just wraps, which keeps a stray zero write harmless
         end else if (i_period != CTP_CNT_ZERO && s_r.count + CTP_CNT_ONE == i_period) begin
            s_nxt.count = CTP_CNT_ZERO;
            s_nxt.match = 1'b1;
            if (i_mode == CTP_MODE_DIV) begin
               s_nxt.ff = ~s_r.ff;
            end
         end else begin
            s_nxt.count = s_r.count + CTP_CNT_ONE;
         end
      end
   end

   // single state register
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_count = s_r.count;
   assign o_match = s_r.match;
   assign o_ovf = s_r.ovf;
   assign o_ff = s_r.ff;
endmodule : ctp_unit
`default_nettype wire

/* File: ctp_timer_pair.sv */
// top of the cascadable timer/counter pair: clock selection, cascade and 16-bit modes
`timescale 1ns/10ps
`default_nettype none
module ctp_timer_pair
   import ctp_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire ctp_ctrl_t i_lower_ctrl,
   input wire ctp_ctrl_t i_upper_ctrl,
   input wire logic [7:0] i_lower_period,
   input wire logic [7:0] i_upper_period,
   input wire logic [7:0] i_lower_width,
   input wire logic [7:0] i_upper_width,
   input wire logic i_prescaler_tap_select,
   input wire logic i_slow_mode,
   input wire logic [7:0] i_tap_ticks,
   input wire logic i_lower_pin,
   input wire logic i_upper_pin,
   output logic [7:0] o_lower_count,
   output logic [7:0] o_upper_count,
   output logic o_lower_match_interrupt,
   output logic o_upper_match_interrupt,
   output logic o_lower_out_n,
   output logic o_upper_out_n,
   output logic o_clock_illegal
);
   // i_tap_ticks: one-cycle tick per clock select code, made in this clock domain
   typedef struct packed {
      logic [1:0] pin_meta;
      logic [1:0] pin_sync;
      logic [1:0] pin_last;
      ctp_state_t state;
      logic illegal;
      logic lo_int;
      logic up_int;
      logic lo_out_n;
      logic up_out_n;
      logic [7:0] lo_cnt;
      logic [7:0] up_cnt;
   } ctp_top_t;

   ctp_top_t t_r;
   ctp_top_t t_nxt;
   logic cascade;
   logic lo_run;
   logic up_run;
   logic lo_tick;
   logic up_tick;
   logic [7:0] lo_count;
   logic [7:0] up_count;
   logic lo_match;
   logic up_match;
   logic lo_ff;
   logic up_ff;
   logic [15:0] cnt16;
   logic [15:0] per16;
   logic hit16;

   // tick for one clock select code; pin ticks on a synchronised falling edge
   function automatic logic sel_tick(input logic [2:0] sel, input logic pin_fall,
                                     input logic [7:0] taps);
      if (sel == CTP_CK_PIN) begin
         sel_tick = pin_fall;
      end else begin
         sel_tick = taps[sel];
      end
   endfunction : sel_tick

   // whether a clock select is allowed for the mode in the current power mode
   function automatic logic clk_ok(input logic [2:0] mode, input logic [2:0] sel, input logic slow);
      logic tap4;
      logic ok;
      tap4 = (sel <= CTP_CK_TAP3);
      ok = 1'b0;
      if (mode == CTP_MODE_TIMER || mode == CTP_MODE_DIV || mode == CTP_MODE_T16) begin
         ok = slow ? (sel == CTP_CK_TAP11) : tap4;
         ok = ok | (sel == CTP_CK_PIN); // event counting
      end else if (mode == CTP_MODE_PWM8) begin
         ok = slow ? (sel == CTP_CK_TAP11 || sel == CTP_CK_LOWF) : (sel != CTP_CK_PIN);
      end else if (mode == CTP_MODE_PWM16) begin
         ok = slow ? (sel == CTP_CK_TAP11 || sel == CTP_CK_LOWF || sel == CTP_CK_PIN) : 1'b1;
      end else if (mode == CTP_MODE_WARM) begin
         ok = slow ? (sel == CTP_CK_HIGH) : (sel == CTP_CK_LOWF);
      end else begin
         ok = 1'b0;
      end
      clk_ok = ok;
   endfunction : clk_ok

   assign cascade = i_upper_ctrl.mode[CTP_MODE_MSB];
   // in 16-bit modes the upper run bit starts both halves
   assign lo_run = cascade ? i_upper_ctrl.run : i_lower_ctrl.run;
   assign up_run = i_upper_ctrl.run;
   assign lo_tick = sel_tick(i_lower_ctrl.clk_sel, t_r.pin_last[0] & ~t_r.pin_sync[0], i_tap_ticks);
   // upper steps on the same edge as the lower wrap, so the 16-bit value never shows a torn carry
   assign up_tick = cascade ? (lo_tick && lo_count == CTP_CNT_MAX) :
      sel_tick(i_upper_ctrl.clk_sel, t_r.pin_last[1] & ~t_r.pin_sync[1], i_tap_ticks);
   assign cnt16 = {up_count, lo_count};
   assign per16 = {i_upper_period, i_lower_period};
   // 16-bit match on the tick that would reach the period, as in 8-bit mode; zero period never matches
   assign hit16 = cascade && up_run && lo_tick && (cnt16 + {CTP_CNT_ZERO, CTP_CNT_ONE} == per16)
      && (per16 != {CTP_CNT_ZERO, CTP_CNT_ZERO});

   ctp_unit u_lower (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_run(lo_run && !hit16),
      .i_tick(lo_tick),
      .i_mode(i_lower_ctrl.mode),
      .i_ff_ctl(i_lower_ctrl.ff_ctl),
      .i_period(i_lower_period),
      .i_width(i_lower_width),
      .i_cascade_low(cascade),
      .o_count(lo_count),
      .o_match(lo_match),
      .o_ovf(),
      .o_ff(lo_ff)
   );

   ctp_unit u_upper (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_run(up_run && !hit16),
      .i_tick(up_tick),
      .i_mode(cascade ? CTP_MODE_TIMER : i_upper_ctrl.mode),
      .i_ff_ctl(i_upper_ctrl.ff_ctl),
      .i_period(cascade ? CTP_CNT_ZERO : i_upper_period),
      .i_width(i_upper_width),
      .i_cascade_low(cascade),
      .o_count(up_count),
      .o_match(up_match),
      .o_ovf(),
      .o_ff(up_ff)
   );

   // pin synchronisers, run sequencer and registered outputs
   always_comb begin
      t_nxt = t_r;
      t_nxt.pin_meta = {i_upper_pin, i_lower_pin};
      t_nxt.pin_sync = t_r.pin_meta;
      t_nxt.pin_last = t_r.pin_sync;
      case (t_r.state)
         CTP_ST_IDLE: begin
            if (up_run) begin
               t_nxt.state = CTP_ST_ARM;
            end
         end
         CTP_ST_ARM: begin
            t_nxt.state = up_run ? CTP_ST_RUN : CTP_ST_IDLE;
         end
         CTP_ST_RUN: begin
            if (!up_run) begin
               t_nxt.state = CTP_ST_IDLE;
            end
         end
         default: begin
            t_nxt.state = CTP_ST_IDLE;
         end
      endcase
      // the 16-bit compare collapses both halves to zero on the next edge
      t_nxt.lo_int = lo_match && !cascade;
      t_nxt.up_int = cascade ? (hit16 && up_run) : up_match;
      t_nxt.illegal = (lo_run && !clk_ok(cascade ? i_upper_ctrl.mode : i_lower_ctrl.mode,
                                          i_lower_ctrl.clk_sel, i_slow_mode))
                      || (up_run && !cascade && !clk_ok(i_upper_ctrl.mode, i_upper_ctrl.clk_sel, i_slow_mode));
      t_nxt.lo_out_n = ~lo_ff;
      t_nxt.up_out_n = ~up_ff;
      t_nxt.lo_cnt = lo_count;
      t_nxt.up_cnt = up_count;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         t_r <= '{state: CTP_ST_IDLE, lo_out_n: 1'b1, up_out_n: 1'b1, default: '0};
      end else begin
         t_r <= t_nxt;
      end
   end

   assign o_lower_count = t_r.lo_cnt;
   assign o_upper_count = t_r.up_cnt;
   assign o_lower_match_interrupt = t_r.lo_int;
   assign o_upper_match_interrupt = t_r.up_int;
   assign o_lower_out_n = t_r.lo_out_n;
   assign o_upper_out_n = t_r.up_out_n;
   assign o_clock_illegal = t_r.illegal;
endmodule : ctp_timer_pair
`default_nettype wire

/* File: ctp_timer_pair_monitor.sv */
// port checker for the timer pair
`timescale 1ns/10ps
`default_nettype none
module ctp_timer_pair_monitor
   import ctp_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire ctp_ctrl_t i_lower_ctrl,
   input wire ctp_ctrl_t i_upper_ctrl,
   input wire logic [7:0] i_lower_period,
   input wire logic i_slow_mode,
   input wire logic [7:0] o_lower_count,
   input wire logic [7:0] o_upper_count,
   input wire logic o_lower_match_interrupt,
   input wire logic o_clock_illegal
);
   logic lt;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // lower alone in 8-bit timer mode, upper stopped and not cascaded
   assign lt = i_lower_ctrl.run && i_lower_ctrl.mode == CTP_MODE_TIMER && !i_upper_ctrl.run
      && !i_upper_ctrl.mode[CTP_MODE_MSB];
   low_stop_a: assert property (
      (!i_lower_ctrl.run && !i_upper_ctrl.mode[CTP_MODE_MSB])[*3] |-> o_lower_count == CTP_CNT_ZERO)
      else $error("lower count moves while stopped");
   up_stop_a: assert property (
      (!i_upper_ctrl.run)[*3] |-> o_upper_count == CTP_CNT_ZERO) else $error("upper count moves while stopped");
   irq_single_a: assert property (
      lt && o_lower_match_interrupt && i_lower_period > 8'h01 |=> !o_lower_match_interrupt)
      else $error("match interrupt longer than one cycle");
   irq_clear_a: assert property (
      lt && $stable(i_lower_ctrl) && o_lower_match_interrupt |-> o_lower_count == CTP_CNT_ZERO)
      else $error("counter not cleared on match");
   zero_period_a: assert property (
      (lt && i_lower_period == 8'h00)[*3] |-> !o_lower_match_interrupt) else $error("period zero matched");
   lowf_bad_a: assert property (
      (lt && i_lower_ctrl.clk_sel == CTP_CK_LOWF && !i_slow_mode)[*3] |-> o_clock_illegal)
      else $error("low clock timer not flagged");
   slow_tap_a: assert property (
      (lt && i_lower_ctrl.clk_sel == CTP_CK_TAP7 && i_slow_mode)[*3] |-> o_clock_illegal)
      else $error("fast tap in slow mode not flagged");
   tap_legal_a: assert property (
      (lt && i_lower_ctrl.clk_sel == CTP_CK_TAP11)[*3] |-> !o_clock_illegal) else $error("slowest tap flagged");
   cascade_carry_a: assert property (
      i_upper_ctrl.mode[CTP_MODE_MSB] && $past(i_upper_ctrl.mode[CTP_MODE_MSB]) && $changed(o_upper_count)
      && o_upper_count != CTP_CNT_ZERO |-> $past(o_lower_count) == CTP_CNT_MAX) else $error("upper moved w/o carry");
endmodule : ctp_timer_pair_monitor
bind ctp_timer_pair ctp_timer_pair_monitor u_mon (.i_clk_sys, .i_reset, .i_lower_ctrl, .i_upper_ctrl,
   .i_lower_period, .i_slow_mode, .o_lower_count, .o_upper_count, .o_lower_match_interrupt, .o_clock_illegal);
`default_nettype wire

/* File: ctp_timer_pair_bench.sv */
// self-checking bench for the timer pair
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module ctp_timer_pair_bench
   import ctp_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic slow = 1'b0;
   logic lpin = 1'b1;
   ctp_ctrl_t lc = '0;
   ctp_ctrl_t uc = '0;
   logic [7:0] lp = 8'h00;
   logic [7:0] up = 8'h00;
   logic [7:0] lcnt;
   logic [7:0] ucnt;
   logic lirq;
   logic uirq;
   logic ill_o;
   logic lout;
   logic uout;
   int miscompares = 0;
   int n_compared = 0;
   int lirqs = 0;
   always #12.5 clk = ~clk;
   ctp_timer_pair dut (.i_clk_sys(clk), .i_reset(rst), .i_lower_ctrl(lc), .i_upper_ctrl(uc),
      .i_lower_period(lp), .i_upper_period(up), .i_lower_width(8'h80), .i_upper_width(8'h80),
      .i_prescaler_tap_select(1'b0), .i_slow_mode(slow), .i_tap_ticks(8'h7F), .i_lower_pin(lpin),
      .i_upper_pin(1'b1), .o_lower_count(lcnt), .o_upper_count(ucnt), .o_lower_match_interrupt(lirq),
      .o_upper_match_interrupt(uirq), .o_lower_out_n(lout), .o_upper_out_n(uout), .o_clock_illegal(ill_o));
   // inputs move 2 ns after each edge, so every edge sees settled values
   task automatic step;
      @(posedge clk);
      #2;
      if (lirq === 1'b1) lirqs++;
   endtask : step
   task automatic wait_irq(input logic u, output int n);
      n = 0;
      do begin step(); n++; end while ((u ? uirq : lirq) !== 1'b1 && n < 700);
   endtask : wait_irq
   // spacing of two interrupts is latency free, unlike the first one
   task automatic gap(input logic u, input int e);
      int n;
      wait_irq(u, n);
      wait_irq(u, n);
      `CHK(n, e)
   endtask : gap
   task automatic t_timer;
      lp = 8'h05;
      up = 8'h03;
      lc = '{CTP_MODE_TIMER, CTP_CK_TAP3, 1'b1, 1'b0};
      uc = '{CTP_MODE_TIMER, CTP_CK_TAP5, 1'b1, 1'b0};
      gap(1'b0, 5);
      gap(1'b1, 3);
      lc.run = 1'b0;
      uc.run = 1'b0;
      repeat (3) step();
      `CHK(lcnt, CTP_CNT_ZERO)
      `CHK(ucnt, CTP_CNT_ZERO)
      `CHK(lout, 1'b1)
      `CHK(uout, 1'b1)
      $display("t_timer done");
   endtask : t_timer
   task automatic t_rewrite;
      int n;
      lp = 8'hC8;
      lc.run = 1'b1;
      repeat (10) step();
      lp = 8'h14;
      wait_irq(1'b0, n);
      `CHK(n < 15, 1'b1)
      lp = 8'h00;
      n = lirqs;
      // long enough for the counter to wrap, so a match at the wrap would show
      repeat (300) step();
      `CHK(lirqs, n)
      lc.run = 1'b0;
      $display("t_rewrite done");
   endtask : t_rewrite
   // divider: the stopped flip-flop takes the preset, then toggles on every match
   task automatic t_div;
      int n;
      step();
      lp = 8'h04;
      lc = '{CTP_MODE_DIV, CTP_CK_TAP3, 1'b0, 1'b1};
      repeat (4) step();
      `CHK(lout, 1'b0)
      lc.run = 1'b1;
      wait_irq(1'b0, n);
      `CHK(lout, 1'b1)
      wait_irq(1'b0, n);
      `CHK(n, 4)
      `CHK(lout, 1'b0)
      lc.run = 1'b0;
      step();
      $display("t_div done");
   endtask : t_div
   task automatic t_cascade;
      lc = '{CTP_MODE_LOWER16, CTP_CK_TAP3, 1'b0, 1'b0}; // lower run bit has no say here
      uc = '{CTP_MODE_T16, CTP_CK_PIN, 1'b1, 1'b0}; // own clock select must be ignored
      lp = 8'h04;
      up = 8'h01;
      gap(1'b1, 260);
      `CHK(ill_o, 1'b0)
      uc.run = 1'b0;
      repeat (3) step();
      `CHK(ucnt, CTP_CNT_ZERO)
      $display("t_cascade done");
   endtask : t_cascade
   task automatic t_pin;
      int n;
      uc = '0;
      lc = '{CTP_MODE_TIMER, CTP_CK_PIN, 1'b1, 1'b0};
      lp = 8'h03;
      n = lirqs;
      repeat (6) begin
         lpin = 1'b0;
         repeat (4) step();
         lpin = 1'b1;
         repeat (4) step();
      end
      `CHK(lirqs - n, 2)
      `CHK(ill_o, 1'b0)
      $display("t_pin done");
   endtask : t_pin
   task automatic ill(input logic [2:0] ml, ck, mu, input logic s, e);
      // stop first: fields may only change together with a start
      lc.run = 1'b0;
      uc.run = 1'b0;
      step();
      lc = '{ml, ck, !mu[CTP_MODE_MSB], 1'b0};
      uc = '{mu, CTP_CK_TAP11, mu[CTP_MODE_MSB], 1'b0};
      slow = s;
      repeat (4) step();
      `CHK(ill_o, e)
   endtask : ill
   task automatic t_clock;
      for (int s = 0; s < 2; s++)
         for (int c = 0; c < 7; c++)
            ill(CTP_MODE_TIMER, 3'(c), CTP_MODE_TIMER, s[0], s ? c != 0 : c > 3);
      ill(CTP_MODE_PWM8, CTP_CK_LOWF, CTP_MODE_TIMER, 1'b1, 1'b0);
      ill(CTP_MODE_PWM8, CTP_CK_HIGH, CTP_MODE_TIMER, 1'b1, 1'b1);
      ill(CTP_MODE_LOWER16, CTP_CK_LOWF, CTP_MODE_WARM, 1'b0, 1'b0);
      ill(CTP_MODE_LOWER16, CTP_CK_HIGH, CTP_MODE_WARM, 1'b1, 1'b0);
      ill(CTP_MODE_LOWER16, CTP_CK_TAP7, CTP_MODE_T16, 1'b1, 1'b1);
      $display("t_clock done");
   endtask : t_clock
   task automatic results;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results
   initial begin
      repeat (5) @(posedge clk);
      #2;
      rst = 1'b0;
      t_timer();
      t_rewrite();
      t_div();
      t_cascade();
      t_pin();
      t_clock();
      results();
   end
   // about four times the expected run length
   initial begin
      #100000;
      miscompares++;
      results();
   end
endmodule : ctp_timer_pair_bench
`default_nettype wire
